// >>> hw/spgp_port.sv
// Six-pin port, five pins bidirectional and pin 5 input-only, with peripheral overrides and Avalon-MM slave.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "spgp_cfg.svh"
module spgp_port (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic reset_pin_select_cfg,
   input wire logic [5:0] pin_in,
   output logic [4:0] pin_out,
   output logic [4:0] pin_oe,
   output logic master_clear_in,
   input wire logic vpp_high_detect,
   output logic prog_entry_detect,
   input wire spgp_pkg::spgp_periph_s periph,
   output spgp_pkg::spgp_periph_in_s periph_in
);
   spgp_pkg::spgp_state_s state;
   spgp_pkg::spgp_state_s next_state;
   logic [4:0] drv_en;
   logic [4:0] drv_val;
   logic [7:0] rd_byte;
   logic wr_low;

   // Builds one zero-padded read byte from a field and its bit 5.
   function automatic logic [7:0] spgp_pack(input logic [4:0] lo,
                                            input logic b5);
      spgp_pack = {2'h0, b5, lo};
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Pin driver selection, per-pin peripheral priority.
   always_comb begin
      drv_en = ~state.direction;
      drv_val = state.latch;
      // Pin 0: unit 3 output beats enhanced PWM channel and port.
      if (periph.cc3_out_en) begin
         drv_en[0] = 1'h1;
         drv_val[0] = periph.cc3_out;
      end else if (periph.pwm3a_en) begin
         drv_en[0] = ~periph.pwm_shutdown_tri;
         drv_val[0] = periph.pwm3a_out;
      end
      // Pin 1: transmit data, or clock out unless a sync slave.
      if (periph.ser2_en && !(periph.ser2_sync && periph.ser2_slave)) begin
         drv_en[1] = 1'h1;
         drv_val[1] = periph.ser2_tx_clk;
      end
      // Pin 2: sync data driven by the serial unit when it transmits.
      if (periph.ser2_en && periph.ser2_sync && periph.ser2_dt_drive) begin
         drv_en[2] = 1'h1;
         drv_val[2] = periph.ser2_dt_out;
      end else if (periph.ser2_en) begin
         drv_en[2] = 1'h0;
      end
      // Pin 3: unit 4 output, then enhanced PWM channel D.
      if (periph.cc4_out_en) begin
         drv_en[3] = 1'h1;
         drv_val[3] = periph.cc4_out;
      end else if (periph.pwm3d_en) begin
         drv_en[3] = ~periph.pwm_shutdown_tri;
         drv_val[3] = periph.pwm3d_out;
      end
      // Pin 4: unit 5 output, then enhanced PWM unit 1 channel.
      if (periph.cc5_out_en) begin
         drv_en[4] = 1'h1;
         drv_val[4] = periph.cc5_out;
      end else if (periph.pwm1d_en) begin
         drv_en[4] = ~periph.pwm_shutdown_tri;
         drv_val[4] = periph.pwm1d_out;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read data multiplexer.
   always_comb begin
      case (avs_address)
         `SPGP_OFS_PIN_LEVELS: begin
            rd_byte = spgp_pack(state.pins[4:0],
                                state.pins[5] & ~reset_pin_select_cfg);
         end
         `SPGP_OFS_OUTPUT_LATCH: begin
            rd_byte = spgp_pack(state.latch,
                                state.latch5 & ~reset_pin_select_cfg);
         end
         `SPGP_OFS_DIRECTION: begin
            rd_byte = spgp_pack(state.direction, 1'h0);
         end
         `SPGP_OFS_OVERRIDE_EN: begin
            rd_byte = spgp_pack(drv_en, 1'h0);
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Next state: synchroniser, register writes and read answer.
   always_comb begin
      next_state = state;
      wr_low = avs_write && avs_byteenable[0];
      // Three-stage pin sampler; a level counts once stages two and three agree.
      next_state.sync1 = pin_in;
      next_state.sync2 = state.sync1;
      next_state.sync3 = state.sync2;
      for (int i = 0; i < 6; i++) begin
         if (state.sync2[i] == state.sync3[i]) begin
            next_state.pins[i] = state.sync3[i];
         end
      end
      // Writes to the level or latch register both load the latch.
      if (wr_low && (avs_address == `SPGP_OFS_PIN_LEVELS ||
                     avs_address == `SPGP_OFS_OUTPUT_LATCH)) begin
         next_state.latch = avs_writedata[4:0];
         next_state.latch5 = avs_writedata[`SPGP_BIT_INPUT_ONLY];
      end
      if (wr_low && avs_address == `SPGP_OFS_DIRECTION) begin
         next_state.direction = avs_writedata[4:0];
      end
      // Reads answer one cycle after the request, then release.
      next_state.rd_done = avs_read && !state.rd_done;
      if (avs_read && !state.rd_done) begin
         next_state.readdata = {24'h000000, rd_byte};
      end
      if (!reset_n) begin
         next_state.direction = `SPGP_RST_DIRECTION;
         next_state.latch = `SPGP_RST_LATCH;
         next_state.latch5 = `SPGP_RST_LATCH5;
         next_state.sync1 = 6'h00;
         next_state.sync2 = 6'h00;
         next_state.sync3 = 6'h00;
         next_state.pins = 6'h00;
         next_state.readdata = 32'h00000000;
         next_state.rd_done = 1'h0;
      end
   end

   // State register, synchronous reset applied in the next-state logic.
   always_ff @(posedge clk) begin
      state <= next_state;
   end

   //////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign avs_waitrequest = avs_read && !state.rd_done;
   assign avs_readdata = state.readdata;
   assign pin_oe = drv_en;
   assign pin_out = drv_val;
   // Pin 5 goes to reset logic only when selected, active low as a pin.
   assign master_clear_in = reset_pin_select_cfg & ~state.pins[5];
   assign prog_entry_detect = vpp_high_detect;
   // Capture and serial inputs see the sampled pins.
   assign periph_in.cc3_capture = state.pins[0];
   assign periph_in.ser2_clk_in = state.pins[1];
   assign periph_in.ser2_rx = state.pins[2];
   assign periph_in.cc4_capture = state.pins[3];
   assign periph_in.cc5_capture = state.pins[4];
endmodule // spgp_port
`default_nettype wire

// >>> hw/spgp_cfg.svh
// Offsets, reset values and field positions of the six-pin port.
`ifndef SPGP_CFG_SVH
`define SPGP_CFG_SVH
`define SPGP_OFS_PIN_LEVELS 2'h0
`define SPGP_OFS_OUTPUT_LATCH 2'h1
`define SPGP_OFS_DIRECTION 2'h2
`define SPGP_OFS_OVERRIDE_EN 2'h3
`define SPGP_RST_DIRECTION 5'h1F
`define SPGP_RST_LATCH 5'h00
`define SPGP_RST_LATCH5 1'h0
`define SPGP_BIT_INPUT_ONLY 5
`define SPGP_BIDIR_PINS 5
`endif

// >>> hw/spgp_pkg.sv
// Types shared by the six-pin port.
`default_nettype none
package spgp_pkg;
   // Peripheral requests toward the pins.
   typedef struct packed {
      logic cc3_out_en;
      logic cc3_out;
      logic ser2_en;
      logic ser2_sync;
      logic ser2_slave;
      logic ser2_tx_clk;
      logic ser2_dt_drive;
      logic ser2_dt_out;
      logic cc4_out_en;
      logic cc4_out;
      logic cc5_out_en;
      logic cc5_out;
      logic pwm3a_en;
      logic pwm3a_out;
      logic pwm3d_en;
      logic pwm3d_out;
      logic pwm1d_en;
      logic pwm1d_out;
      logic pwm_shutdown_tri;
   } spgp_periph_s;

   // Pin values handed back to the peripherals.
   typedef struct packed {
      logic cc3_capture;
      logic ser2_clk_in;
      logic ser2_rx;
      logic cc4_capture;
      logic cc5_capture;
   } spgp_periph_in_s;

   typedef struct packed {
      logic [4:0] direction;
      logic [4:0] latch;
      logic latch5;
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [5:0] sync3;
      logic [5:0] pins;
      logic [31:0] readdata;
      logic rd_done;
   } spgp_state_s;
endpackage
`default_nettype wire

// >>> bench/spgp_port_asserts.sv
// Assertions watching the six-pin port at its ports.
`timescale 1ns/10ps
`default_nettype none
module spgp_port_asserts (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic reset_pin_select_cfg,
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   input wire logic master_clear_in,
   input wire spgp_pkg::spgp_periph_s periph
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Steps of a register access.
   sequence dir_wr;
      avs_write && avs_byteenable[0] && avs_address == 2'h2 && periph == '0;
   endsequence
   sequence rd_ack;
      avs_read && !avs_waitrequest;
   endsequence
   // Bus timing, read values and pin drive.
   read_wait_a:
      assert property (avs_read && !$past(avs_read) |-> avs_waitrequest)
      else $error("read not stalled");
   dir_drive_a:
      assert property (dir_wr |=> pin_oe == ~$past(avs_writedata[4:0]))
      else $error("drive enable wrong");
   unimpl_zero_a:
      assert property (rd_ack |-> avs_readdata[31:6] == '0
         && !(avs_address == 2'h2 && avs_readdata[5])) else $error("bad bits");
   master_clear_in_bit5_a:
      assert property (rd_ack ##0 reset_pin_select_cfg && !avs_address[1]
         |-> !avs_readdata[5]) else $error("bit 5 not zero");
   master_clear_in_cfg_a:
      assert property (master_clear_in |-> reset_pin_select_cfg)
      else $error("reset from port pin");
   cc3_first_a:
      assert property (periph.cc3_out_en |-> pin_oe[0]
         && pin_out[0] == periph.cc3_out) else $error("pin 0 wrong");
   ser2_tx_a:
      assert property (periph.ser2_en && !periph.ser2_sync |-> pin_oe[1]
         && pin_out[1] == periph.ser2_tx_clk) else $error("pin 1 wrong");
   cc5_first_a:
      assert property (periph.cc5_out_en |-> pin_oe[4]
         && pin_out[4] == periph.cc5_out) else $error("pin 4 wrong");
endmodule // spgp_port_asserts
////////////////////////////////////////////////////////////////////////////
bind spgp_port spgp_port_asserts chk (.clk, .reset_n, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .reset_pin_select_cfg, .pin_out, .pin_oe,
   .master_clear_in, .periph);
`default_nettype wire

// >>> bench/spgp_pins_model.sv
// Model of the circuitry outside the six port pins.
`timescale 1ns/10ps
`default_nettype none
module spgp_pins_model (
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   input wire logic [5:0] ext_level,
   output logic [5:0] pin_level
);
   // A driven pin shows the port's value; pin 5 is only ever outside.
   assign pin_level = {ext_level[5],
      (pin_oe & pin_out) | (~pin_oe & ext_level[4:0])};
endmodule // spgp_pins_model
`default_nettype wire

// >>> bench/testbench.sv
// Register and pin tests of the six-pin port.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic reset_pin_select_cfg = 1'b0, vpp_high_detect = 1'b0;
   logic avs_waitrequest, master_clear_in, prog_entry_detect;
   logic [1:0] avs_address = 2'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
   logic [4:0] pin_out, pin_oe;
   logic [5:0] pin_in, ext_level = 6'h2A;
   spgp_pkg::spgp_periph_s periph = '0;
   spgp_pkg::spgp_periph_in_s periph_in;
   int mismatches = 0;
   int cmp_count = 0;
   spgp_port uut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .reset_pin_select_cfg, .pin_in, .pin_out, .pin_oe, .master_clear_in,
      .vpp_high_detect, .prog_entry_detect, .periph, .periph_in);
   spgp_pins_model pins (.pin_out, .pin_oe, .ext_level, .pin_level(pin_in));
   // Clock at 50 MHz.
   initial begin
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("mismatches %0d compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Waits, bounded, for an edge with waitrequest low.
   task automatic wait_ack();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin
         mismatches++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d, be = 8'h0F);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be[3:0];
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      chk("readdata", avs_readdata, {24'h000000, e});
      avs_read <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      rd(2'h2, 8'h1F);
      rd(2'h1, 8'h00);
      wr(2'h1, 8'h15);
      wr(2'h2, 8'h00);
      wr(2'h2, 8'h1F, 8'h0E);
      wr(2'h3, 8'h1F);
      repeat (8) @(posedge clk);
      chk("pin_oe", 32'(pin_oe), 32'h0000001F);
      chk("pin_out", 32'(pin_out), 32'h00000015);
      chk("master_clear_in", 32'(master_clear_in), 32'h00000000);
      rd(2'h0, 8'h35);
      wr(2'h2, 8'h1F);
      repeat (8) @(posedge clk);
      rd(2'h0, 8'h2A);
      rd(2'h1, 8'h15);
      wr(2'h0, 8'h03);
      rd(2'h1, 8'h03);
      reset_pin_select_cfg <= 1'b1;
      ext_level <= 6'h0A;
      vpp_high_detect <= 1'b1;
      repeat (8) @(posedge clk);
      chk("master_clear_in", 32'(master_clear_in), 32'h00000001);
      chk("prog_entry_detect", 32'(prog_entry_detect), 32'h00000001);
      rd(2'h0, 8'h0A);
      // Unit 3 output high, serial 2 async transmit, unit 5 output enabled.
      periph <= 19'h70100;
      @(negedge clk);
      chk("pin_oe", 32'(pin_oe), 32'h00000013);
      chk("pin_out", 32'(pin_out & 5'h13), 32'h00000001);
      rd(2'h2, 8'h1F);
      // Unit 4 output high beats channel D; unit 1 channel D drives pin 4.
      periph <= 19'h00616;
      @(negedge clk);
      chk("pin_oe", 32'(pin_oe), 32'h00000018);
      chk("pin_out", 32'(pin_out & 5'h18), 32'h00000018);
      @(posedge clk);
      rd(2'h3, 8'h18);
      // Shutdown tri-states the PWM channels; serial 2 as a sync slave.
      periph <= 19'h1C017;
      repeat (8) @(posedge clk);
      chk("pin_oe", 32'(pin_oe), 32'h00000000);
      chk("periph_in", 32'(periph_in), 32'h0000000A);
      reset_pin_select_cfg <= 1'b0;
      vpp_high_detect <= 1'b0;
      @(negedge clk);
      chk("prog_entry_detect", 32'(prog_entry_detect), 32'h00000000);
      chk("master_clear_in", 32'(master_clear_in), 32'h00000000);
      stop_test();
   end
endmodule // testbench
`default_nettype wire
